// ==== hw/plmr_pkg.sv ====
// plmr_pkg: shared types and constants of the link-mode resolution block.
// assumes a 200 MHz core clock; only the crossover dwell count derives from the period below.
package plmr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS   = 5;     // core clock period
    localparam int XOVER_DWELL_NS  = 10000; // time spent on one pair setting
    localparam int XOVER_DWELL_CYC = XOVER_DWELL_NS / CLK_PERIOD_NS;
    localparam int RXC_HALF_CYC    = 4;     // receive clock half period
    localparam int STRAP_WAIT_CYC  = 3;     // strap settles through sync

    ////////////////////////////////////////////////////////////////////////
    // gigabit role advertisement of either side
    typedef enum logic [1:0] {
        ADV_SINGLE  = 2'b00,
        ADV_MULTI   = 2'b01,
        ADV_MMASTER = 2'b10,
        ADV_MSLAVE  = 2'b11
    } plmr_adv_t;

    // resolved link speed
    typedef enum logic [1:0] {
        SPD_10   = 2'b00,
        SPD_100  = 2'b01,
        SPD_1000 = 2'b10
    } plmr_spd_t;

    // master/slave outcome
    typedef struct packed {
        logic link_ok; // gigabit link may come up
        logic master;  // this end is master
        logic fault;   // both forced to the same role
    } plmr_ms_t;

    // one nibble plus its control line
    typedef struct packed {
        logic       ctrl;
        logic [3:0] d;
    } plmr_nib_t;

    // software configuration word
    typedef struct packed {
        logic auto_mdix_dis;
        logic partial_en;
        logic pair01_manual_cross;
        logic pair23_manual_cross;
        logic txc_dly;
        logic rxc_dly;
    } plmr_cfg_t;

    // delay-enable encodings {txc, rxc}
    localparam logic [1:0] DLY_NONE   = 2'b00;
    localparam logic [1:0] DLY_ID     = 2'b01;
    localparam logic [1:0] DLY_HYBRID = 2'b11;

    // reset value apart from the strapped delay bits
    localparam plmr_cfg_t CFG_RST = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

endpackage

// ==== hw/plmr_sync.sv ====
// plmr_sync: two-flop synchroniser for a bundle of pin levels.
// assumes each bit is an independent slow level or a sampled clock.
`timescale 1ns/10ps
module plmr_sync #(
    parameter int W = 1
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_ff; // first stage, read only by o_q

    // both stages clear on reset
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_ff <= '0;
            o_q     <= '0;
        end else begin
            meta_ff <= i_d;
            o_q     <= meta_ff;
        end
    end
endmodule

// ==== hw/plmr_xover.sv ====
// plmr_xover: pair crossover search and manual override.
// assumes i_pair_lock comes from line logic on the core clock.
`timescale 1ns/10ps
module plmr_xover
    import plmr_pkg::*;
#(
    parameter int DWELL = XOVER_DWELL_CYC
) (
    input  wire logic i_core_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_restart,
    input  wire logic i_gig,
    input  wire plmr_cfg_t i_cfg,
    input  wire logic i_pair_lock,
    output logic      o_cross01,
    output logic      o_cross23,
    output logic      o_done
);
    typedef enum logic [2:0] {
        XO_STRAIGHT = 3'b000,
        XO_CROSS    = 3'b001,
        XO_C23      = 3'b010,
        XO_C01      = 3'b011,
        XO_DONE     = 3'b100,
        XO_MANUAL   = 3'b101
    } plmr_xo_t;

    plmr_xo_t           state_ff;  // current trial
    plmr_xo_t           nxt_state;
    logic [15:0]        dwell_ff;  // cycles on this trial
    logic               expire;

    assign expire = (dwell_ff == 16'(DWELL - 1));

    ////////////////////////////////////////////////////////////////////////
    // next trial; partial steps only when 2/3 carry signal
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            XO_STRAIGHT, XO_CROSS, XO_C23, XO_C01: begin
                if (i_pair_lock) begin
                    nxt_state = XO_DONE;
                end else if (expire) begin
                    unique case (state_ff)
                        XO_STRAIGHT: nxt_state = XO_CROSS;
                        XO_CROSS: nxt_state = (i_cfg.partial_en && i_gig) ? XO_C23 : XO_STRAIGHT; // RULE15 RULE16
                        XO_C23: nxt_state = XO_C01; // RULE15
                        default: nxt_state = XO_STRAIGHT;
                    endcase
                end
            end
            XO_DONE, XO_MANUAL: nxt_state = state_ff;
            default: nxt_state = XO_STRAIGHT;
        endcase
        if (i_cfg.auto_mdix_dis) begin
            nxt_state = XO_MANUAL; // RULE14
        end else if (i_restart || state_ff == XO_MANUAL) begin
            nxt_state = XO_STRAIGHT;
        end
    end

    // state and dwell counter
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_ff <= XO_STRAIGHT;
            dwell_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            dwell_ff <= (nxt_state != state_ff) ? 16'h0000 : dwell_ff + 16'h0001;
        end
    end

    // pair swaps; the search swaps 2/3 only in gigabit, manual mode takes both bits as set
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_cross01 <= 1'b0;
            o_cross23 <= 1'b0;
            o_done    <= 1'b0;
        end else begin
            unique case (nxt_state)
                XO_MANUAL: begin
                    o_cross01 <= i_cfg.pair01_manual_cross; // RULE14
                    o_cross23 <= i_cfg.pair23_manual_cross;
                end
                XO_DONE: begin
                    o_cross01 <= o_cross01;
                    o_cross23 <= o_cross23;
                end
                default: begin
                    o_cross01 <= (nxt_state == XO_CROSS) || (nxt_state == XO_C01); // RULE12
                    o_cross23 <= i_gig && ((nxt_state == XO_CROSS) || (nxt_state == XO_C23));
                end
            endcase
            o_done <= (nxt_state == XO_DONE) || (nxt_state == XO_MANUAL);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_c23_after_cross: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (state_ff == XO_C23) |-> $past(state_ff) inside {XO_CROSS, XO_C23}) // RULE15
        else $error("pair 2/3 trial not preceded by full cross");
    a_no23_below_gig: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (!$past(i_gig) && !$past(i_cfg.auto_mdix_dis) && !o_done) |-> !o_cross23) // RULE12
        else $error("pair 2/3 swapped outside gigabit");
    c_partial_c01: cover property (@(posedge i_core_clk) state_ff == XO_C01);
endmodule

// ==== hw/plmr_top.sv ====
// plmr_top: gigabit role resolution, forced speed, carrier sense,
// pair crossover and receive-clock delay control of a copper transceiver.
// assumes a 200 MHz core clock; transmit pins come from the mac's clock.
//
// Function
// RULE1: same forced role on both sides: no link
// RULE2: forced slave resolves slave against port preference
// RULE3: forced master resolves master against multi-port
// RULE4: no negotiation: forced 10/100 speed and duplex
// RULE5: forced path never gives gigabit
// RULE6: half duplex: receive during transmit is collision
// RULE7: full duplex: no collision, both directions together
// RULE8: half duplex carrier follows transmit and receive
// RULE9: full duplex carrier follows receive only
// RULE10: gigabit keeps carrier sense low
// RULE11: active mode follows carrier, low mode stays low
// RULE12: swap pairs 0/1, and 2/3 in gigabit
// RULE13: crossover settles before link pulses start
// RULE14: auto crossover default on, manual bits when off
// RULE15: partial order: 2/3 swapped, then 0/1 swapped
// RULE16: partial crossover default on, own enable
// RULE17: report 0:1 and 2:3 crossover result bits
// RULE18: mac drives transmit clock, data, control
// RULE19: device drives receive clock, data, control
// RULE20: id mode delays receive clock here only
// RULE21: hybrid mode delays both clocks here
// RULE22: two delay bits, strap default, id is 01
// RULE23: speed and duplex bits ignored while negotiating
// RULE24: equal preference: random seeds pick roles
`timescale 1ns/10ps
module plmr_top #(
    parameter int SEED_W = 16 // width of the role seeds
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_sys_rst,
    // configuration
    input  wire logic              i_aneg_en,
    input  wire logic [1:0]        i_speed_sel,
    input  wire logic              i_duplex_sel,
    input  wire logic              i_ms_manual_en,
    input  wire logic              i_ms_manual_master,
    input  wire logic              i_ms_multi_port,
    input  wire logic              i_cfg_wr,
    input  wire plmr_pkg::plmr_cfg_t i_cfg,
    input  wire logic              i_crs_active_mode,
    // negotiation outcome
    input  wire plmr_pkg::plmr_adv_t i_lp_adv,
    input  wire logic [SEED_W-1:0] i_seed_local,
    input  wire logic [SEED_W-1:0] i_seed_lp,
    input  wire plmr_pkg::plmr_spd_t i_neg_speed,
    input  wire logic              i_neg_full_dup,
    input  wire logic              i_gig_adv,
    // line side
    input  wire logic              i_pair_lock,
    input  wire logic              i_link_lost,
    input  wire plmr_pkg::plmr_nib_t i_line_rx,
    input  wire logic              i_line_crs,
    // mac transmit pins and strap
    input  wire logic              i_txc,
    input  wire logic              i_txctrl,
    input  wire logic [3:0]        i_txd,
    input  wire logic              i_delay_mode_strap,
    // outputs
    output logic                   o_rxc,
    output plmr_pkg::plmr_nib_t    o_rx,
    output plmr_pkg::plmr_nib_t    o_tx,
    output logic                   o_crs,
    output logic                   o_col,
    output plmr_pkg::plmr_spd_t    o_speed,
    output logic                   o_full_dup,
    output plmr_pkg::plmr_ms_t     o_ms,
    output logic                   o_link_allow,
    output logic                   o_xover_done,
    output logic                   o_flp_go,
    output logic                   o_cross01,
    output logic                   o_cross23,
    output logic                   o_pair01_cross_result,
    output logic                   o_pair23_cross_result,
    output logic                   o_txc_dly_en,
    output logic                   o_rxc_dly_en
);
    import plmr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations
    plmr_cfg_t   cfg_ff;       // live configuration
    logic [1:0]  strap_cnt_ff; // waits for strap through sync
    logic        strap_done_ff;
    logic [6:0]  pins_q;       // synced {strap, txc, txctrl, txd}
    logic        txc_q_ff;     // previous synced transmit clock
    logic        txc_rise;
    logic        rise_d_ff;    // rise seen one cycle late
    logic        take_tx;
    logic        tx_act_ff;    // mac transmitting
    plmr_adv_t   local_adv;
    plmr_ms_t    nxt_ms;
    logic        gig;
    logic [2:0]  rxc_cnt_ff;   // receive clock divider
    logic        rxc_base_ff;
    logic        nxt_rxc_base;
    logic        done_q_ff;
    logic        xo_done;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; strap shares the bundle
    plmr_sync #(
        .W (7)
    ) u_sync (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_d        ({i_delay_mode_strap, i_txc, i_txctrl, i_txd}),
        .o_q        (pins_q)
    );

    // edge of the sampled transmit clock; only the second stage is read
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            txc_q_ff  <= 1'b0;
            rise_d_ff <= 1'b0;
        end else begin
            txc_q_ff  <= pins_q[5];
            rise_d_ff <= txc_rise;
        end
    end
    assign txc_rise = pins_q[5] && !txc_q_ff;

    // with our own txc delay the sample point moves one cycle later
    assign take_tx = cfg_ff.txc_dly ? rise_d_ff : txc_rise; // RULE21

    // transmit nibble and activity, taken on the mac's clock edge
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_tx      <= '0;
            tx_act_ff <= 1'b0;
        end else if (take_tx) begin
            o_tx      <= plmr_nib_t'(pins_q[4:0]);
            tx_act_ff <= pins_q[4];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strap capture: a level caught after release, not under reset
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            strap_cnt_ff  <= 2'h0;
            strap_done_ff <= 1'b0;
        end else if (!strap_done_ff) begin
            strap_cnt_ff  <= strap_cnt_ff + 2'h1;
            strap_done_ff <= (strap_cnt_ff == 2'(STRAP_WAIT_CYC - 1));
        end
    end

    // configuration word; delay bits default from the strap
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cfg_ff <= CFG_RST; // RULE14 RULE16
        end else if (!strap_done_ff) begin
            if (strap_cnt_ff == 2'(STRAP_WAIT_CYC - 1)) begin
                {cfg_ff.txc_dly, cfg_ff.rxc_dly} <= pins_q[6] ? DLY_HYBRID : DLY_NONE; // RULE22
            end
        end else if (i_cfg_wr) begin
            cfg_ff <= i_cfg; // RULE22
        end
    end

    // delay enables shown to the outside; 01 is id mode
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_txc_dly_en <= 1'b0;
            o_rxc_dly_en <= 1'b0;
        end else begin
            o_txc_dly_en <= cfg_ff.txc_dly; // RULE20
            o_rxc_dly_en <= cfg_ff.rxc_dly;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive clock divider; data launched on its rising edge
    assign nxt_rxc_base = (rxc_cnt_ff == 3'(RXC_HALF_CYC - 1)) ? !rxc_base_ff : rxc_base_ff;

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rxc_cnt_ff  <= 3'h0;
            rxc_base_ff <= 1'b0;
        end else begin
            rxc_cnt_ff  <= (rxc_cnt_ff == 3'(RXC_HALF_CYC - 1)) ? 3'h0 : rxc_cnt_ff + 3'h1;
            rxc_base_ff <= nxt_rxc_base;
        end
    end

    // clock out: aligned with data, or one cycle late when delayed
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rxc <= 1'b0;
            o_rx  <= '0;
        end else begin
            o_rxc <= cfg_ff.rxc_dly ? rxc_base_ff : nxt_rxc_base; // RULE19 RULE20
            if (nxt_rxc_base && !rxc_base_ff) begin
                o_rx <= i_line_rx; // RULE19
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // speed and duplex: negotiated result or forced bits
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_speed    <= SPD_10;
            o_full_dup <= 1'b0;
        end else if (i_aneg_en) begin
            o_speed    <= i_neg_speed; // RULE23
            o_full_dup <= i_neg_full_dup;
        end else begin
            // gigabit selection falls back to 100, never forced
            o_speed    <= (i_speed_sel == 2'h0) ? SPD_10 : SPD_100; // RULE4 RULE5
            o_full_dup <= i_duplex_sel; // RULE4
        end
    end

    assign gig = (o_speed == SPD_1000);

    ////////////////////////////////////////////////////////////////////////
    // carrier sense and collision
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_crs <= 1'b0;
            o_col <= 1'b0;
        end else begin
            if (gig || !i_crs_active_mode) begin
                o_crs <= 1'b0; // RULE10 RULE11
            end else if (o_full_dup) begin
                o_crs <= i_line_crs; // RULE9
            end else begin
                o_crs <= i_line_crs || tx_act_ff; // RULE8 RULE11
            end
            // full duplex never flags collision
            o_col <= !o_full_dup && !gig && tx_act_ff && i_line_crs; // RULE6 RULE7
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // gigabit master/slave resolution
    assign local_adv = i_ms_manual_en ? (i_ms_manual_master ? ADV_MMASTER : ADV_MSLAVE)
                                      : (i_ms_multi_port ? ADV_MULTI : ADV_SINGLE);

    always_comb begin
        nxt_ms = '{1'b1, 1'b0, 1'b0};
        if (local_adv == i_lp_adv && i_ms_manual_en) begin
            nxt_ms = '{1'b0, 1'b0, 1'b1}; // RULE1
        end else if (local_adv == ADV_MMASTER) begin
            nxt_ms.master = 1'b1; // RULE3
        end else if (local_adv == ADV_MSLAVE) begin
            nxt_ms.master = 1'b0; // RULE2
        end else if (i_lp_adv == ADV_MMASTER) begin
            nxt_ms.master = 1'b0;
        end else if (i_lp_adv == ADV_MSLAVE) begin
            nxt_ms.master = 1'b1;
        end else if (local_adv != i_lp_adv) begin
            nxt_ms.master = (local_adv == ADV_MULTI);
        end else begin
            // equal seeds give no winner; negotiation retries
            nxt_ms.link_ok = (i_seed_local != i_seed_lp); // RULE24
            nxt_ms.master  = (i_seed_local > i_seed_lp);
        end
    end

    // role outcome and link permission
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_ms         <= '0;
            o_link_allow <= 1'b0;
        end else begin
            o_ms         <= nxt_ms;
            o_link_allow <= !gig || nxt_ms.link_ok; // RULE1
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pair crossover
    plmr_xover u_xover (
        .i_core_clk  (i_core_clk),
        .i_sys_rst   (i_sys_rst),
        .i_restart   (i_link_lost),
        .i_gig       (i_gig_adv),
        .i_cfg       (cfg_ff),
        .i_pair_lock (i_pair_lock),
        .o_cross01   (o_cross01),
        .o_cross23   (o_cross23),
        .o_done      (xo_done)
    );

    // results latched as resolution finishes; pulses wait for it
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            done_q_ff             <= 1'b0;
            o_xover_done          <= 1'b0;
            o_flp_go              <= 1'b0;
            o_pair01_cross_result <= 1'b0;
            o_pair23_cross_result <= 1'b0;
        end else begin
            done_q_ff    <= xo_done;
            o_xover_done <= xo_done;
            o_flp_go     <= xo_done && done_q_ff && i_aneg_en; // RULE13
            if (xo_done && !done_q_ff) begin
                o_pair01_cross_result <= o_cross01; // RULE17
                o_pair23_cross_result <= o_cross23;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);

    a_same_role_down: assert property (
        (i_ms_manual_en && local_adv == i_lp_adv) |=> (!o_ms.link_ok && o_ms.fault)) // RULE1
        else $error("same forced role still allowed a link");
    a_forced_slave: assert property (
        (local_adv == ADV_MSLAVE && i_lp_adv inside {ADV_SINGLE, ADV_MULTI})
        |=> (o_ms.link_ok && !o_ms.master)) // RULE2
        else $error("forced slave did not resolve slave");
    a_forced_master: assert property (
        (local_adv == ADV_MMASTER && i_lp_adv == ADV_MULTI) |=> (o_ms.link_ok && o_ms.master)) // RULE3
        else $error("forced master did not resolve master");
    a_forced_speed: assert property (
        (!i_aneg_en && i_speed_sel == 2'h0) |=> (o_speed == SPD_10 && o_full_dup == $past(i_duplex_sel))) // RULE4
        else $error("forced speed or duplex not applied");
    a_no_forced_gig: assert property (!i_aneg_en |=> o_speed != SPD_1000) // RULE5
        else $error("forced path produced gigabit");
    a_half_col: assert property (
        (!o_full_dup && !gig && tx_act_ff && i_line_crs) |=> o_col) // RULE6
        else $error("collision missed in half duplex");
    a_full_no_col: assert property ($past(o_full_dup) |-> !o_col) // RULE7
        else $error("collision flagged in full duplex");
    a_half_crs_tx: assert property (
        (!gig && !o_full_dup && i_crs_active_mode && tx_act_ff) |=> o_crs) // RULE8
        else $error("carrier did not follow transmit");
    a_full_crs_tx: assert property (
        (!gig && o_full_dup && tx_act_ff && !i_line_crs) |=> !o_crs) // RULE9
        else $error("carrier followed transmit in full duplex");
    a_gig_crs_low: assert property ((gig || !i_crs_active_mode) |=> !o_crs) // RULE10 RULE11
        else $error("carrier high in gigabit or low mode");
    a_flp_wait: assert property (o_flp_go |-> (o_xover_done && $past(o_xover_done))) // RULE13
        else $error("link pulses before crossover settled");
    a_strap_dly: assert property (
        $rose(strap_done_ff) |=> ({o_txc_dly_en, o_rxc_dly_en} == ($past(pins_q[6], 2) ? DLY_HYBRID : DLY_NONE))) // RULE22
        else $error("delay bits not loaded from strap");

    c_collision: cover property (o_col);
    c_seed_master: cover property (o_ms.link_ok && o_ms.master && i_lp_adv == local_adv);
    c_xover_done: cover property ($rose(o_xover_done) ##1 o_flp_go);
endmodule

// ==== bench/plmr_mac_model.sv ====
// plmr_mac_model: behavioural mac driving the transmit pins.
// assumes the device samples txc with its own clock; txc stands still between frames.
`timescale 1ns/10ps
module plmr_mac_model (
    output logic       o_txc,
    output logic       o_txctrl,
    output logic [3:0] o_txd
);
    initial begin
        o_txc = 1'b0;
        o_txctrl = 1'b0;
        o_txd = 4'h0;
    end
    // n nibbles, then one closing beat with ctrl low so the device sees the end
    task automatic send(input int n);
        repeat (n + 1) begin
            o_txc = 1'b0;
            o_txctrl = (n > 0);
            o_txd = o_txd + 4'h3; // data moves each beat, a value repeats only after 16 beats
            n--;
            #32 o_txc = 1'b1;
            #32;
        end
        o_txc = 1'b0;
    endtask
endmodule

// ==== bench/plmr_top_bench.sv ====
// plmr_top_bench: self-checking bench of the link-mode resolution block.
// assumes the mac model on the transmit pins and the fixed 2000-cycle dwell.
`timescale 1ns/10ps
module plmr_top_bench;
    import plmr_pkg::*;
    logic i_core_clk = 0, i_sys_rst = 1, i_aneg_en = 0, i_duplex_sel = 0, i_cfg_wr = 0;
    logic i_ms_manual_en = 0, i_ms_manual_master = 0, i_ms_multi_port = 0, i_gig_adv = 1;
    logic i_crs_active_mode = 1, i_neg_full_dup = 0, i_pair_lock = 0, i_link_lost = 0;
    logic i_line_crs = 0, i_delay_mode_strap = 0, i_txc, i_txctrl;
    logic [1:0] i_speed_sel = 0;
    logic [3:0] i_txd;
    logic [15:0] i_seed_local = 16'h0001, i_seed_lp = 16'h0001;
    plmr_cfg_t i_cfg = CFG_RST;
    plmr_adv_t i_lp_adv = ADV_SINGLE;
    plmr_spd_t i_neg_speed = SPD_1000;
    plmr_nib_t i_line_rx = '0;
    logic o_rxc, o_crs, o_col, o_full_dup, o_link_allow, o_xover_done, o_flp_go, o_cross01;
    logic o_cross23, o_pair01_cross_result, o_pair23_cross_result, o_txc_dly_en, o_rxc_dly_en;
    plmr_nib_t o_rx, o_tx;
    plmr_spd_t o_speed;
    plmr_ms_t o_ms;
    int n_fail = 0, total_checks = 0, hi = 0;
    logic [31:0] rng = 32'h10729e4a;
    // rows {manual, master, partner adv, link_ok master fault}
    localparam logic [6:0] MS [6] = '{7'h71, 7'h59, 7'h44, 7'h4c, 7'h6e, 7'h7e};
    // rows {aneg, full, active, line carrier, crs, col}
    localparam logic [5:0] CS [6] = '{6'h0f, 6'h0a, 6'h18, 6'h1e, 6'h05, 6'h3c};
    localparam logic [1:0] XR [5] = '{2'b00, 2'b11, 2'b01, 2'b10, 2'b00};
    plmr_top dut (.*);
    plmr_mac_model mac (.o_txc(i_txc), .o_txctrl(i_txctrl), .o_txd(i_txd));
    always #2.5 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) i_line_rx <= rng[4:0];
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge i_core_clk);
        i_sys_rst <= 0;
        repeat (6) @(posedge i_core_clk);
        rng = xs(rng);
        i_cfg <= '{1'b1, 1'b1, rng[0], rng[1], 1'b0, 1'b1}; // manual pairs, id delay
        i_cfg_wr <= 1;
        @(posedge i_core_clk);
        i_cfg_wr <= 0;
        repeat (4) @(posedge i_core_clk);
        #1 chk("dly", 4'h1, {o_txc_dly_en, o_rxc_dly_en});
        chk("man", rng[1:0], {o_cross23, o_cross01});
        for (int k = 0; k < 8; k++) begin
            rng = xs(rng);
            @(posedge i_core_clk);
            {i_aneg_en, i_speed_sel} <= k[2:0];
            {i_duplex_sel, i_neg_full_dup} <= rng[1:0];
            i_neg_speed <= plmr_spd_t'(rng[9:8] % 2'd3);
            @(posedge i_core_clk);
            #1 chk("spd", k[2] ? i_neg_speed : {1'b0, k[1:0] != 0}, o_speed);
            chk("dup", k[2] ? i_neg_full_dup : i_duplex_sel, o_full_dup);
        end
        i_aneg_en <= 1;
        i_neg_speed <= SPD_1000;
        for (int k = 0; k < 7; k++) begin
            @(posedge i_core_clk);
            {i_ms_manual_en, i_ms_manual_master} <= k < 6 ? MS[k][6:5] : 2'b01;
            i_lp_adv <= plmr_adv_t'(k < 6 ? MS[k][4:3] : ADV_SINGLE);
            repeat (2) @(posedge i_core_clk);
            if (k < 6) #1 chk("ms", MS[k][2:0], o_ms);
            else #1 chk("seed", 0, o_ms.link_ok);
            chk("allow", k < 6 ? MS[k][2] : 1'b0, o_link_allow);
        end
        i_neg_full_dup <= 1;
        i_speed_sel <= 2'b01;
        fork mac.send(300); join_none
        repeat (40) @(posedge i_core_clk);
        foreach (CS[k]) begin
            {i_aneg_en, i_duplex_sel, i_crs_active_mode, i_line_crs} <= CS[k][5:2];
            repeat (4) @(posedge i_core_clk);
            #1 chk("crscol", CS[k][1:0], {o_crs, o_col});
        end
        i_cfg <= '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
        i_cfg_wr <= 1;
        for (int k = 0; k < 5; k++) begin
            @(posedge i_core_clk);
            {i_cfg_wr, i_pair_lock, i_link_lost} <= 3'b001;
            i_gig_adv <= (k < 4); // last pass without gigabit
            @(posedge i_core_clk);
            i_link_lost <= 0;
            repeat (k * 2000 + 1000) @(posedge i_core_clk);
            i_pair_lock <= 1;
            repeat (4) @(posedge i_core_clk);
            #1 chk("xres", {1'b1, XR[k]}, {o_xover_done, o_pair01_cross_result, o_pair23_cross_result});
            chk("flp", 5'h01, o_flp_go);
        end
        chk("rx", i_line_rx, o_rx);
        chk("tx", {1'b0, i_txd}, o_tx);
        repeat (8) begin
            @(posedge i_core_clk);
            #1 hi += o_rxc;
        end
        chk("rxc", 5'h04, 5'(hi));
        @(posedge i_core_clk);
        i_delay_mode_strap <= 1;
        i_sys_rst <= 1;
        repeat (2) @(posedge i_core_clk);
        i_sys_rst <= 0;
        repeat (6) @(posedge i_core_clk);
        #1 chk("hyb", 5'h03, {o_txc_dly_en, o_rxc_dly_en});
        finish_test();
    end
endmodule
